/* hw/hdlc_diag_loopback_ctrl.v */
// Purpose: host register bank, loopback routing, float, reset, power down
// Assumes: host pins and bit clocks are asynchronous to sys_clk
// Notes:   bit clocks must be well below sys_clk/4 for edge finding
`timescale 1ns/1ps
`default_nettype none
`include "hdlc_diag_defs.vh"
module hdlc_diag_loopback_ctrl #(
    parameter DW = 8,
    parameter AW = 4
) (
    input  wire          sys_clk,
    input  wire          rst_b,
    input  wire          cs_b,
    input  wire          rd_b,
    input  wire          wr_b,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] data_in,
    output wire [DW-1:0] data_out,
    output wire          data_oe_b,
    input  wire          tx_bit_clock,
    input  wire          rx_bit_clock,
    input  wire          serial_in_a,
    input  wire          serial_in_b,
    output wire          serial_out_a,
    output wire          serial_out_a_oe_b,
    output wire          serial_out_b,
    output wire          serial_out_b_oe_b,
    input  wire          tx_serial_bit,
    input  wire          rx_slot_active,
    input  wire          tx_slot_active,
    output wire          rx_serial_bit,
    output wire          rx_bit_strobe,
    output wire          tx_bit_strobe,
    input  wire [DW-1:0] tx_status_in,
    input  wire [DW-1:0] rx_status_in,
    input  wire [DW-1:0] int_status_in,
    input  wire [DW-1:0] fifo_rd_data,
    input  wire [4:0]    transparent_status_in,
    output wire          fifo_wr_strobe,
    output wire [DW-1:0] fifo_wr_data,
    output wire          fifo_rd_strobe,
    output wire          tx_fifo_clear,
    output wire          rx_fifo_clear,
    output wire          tx_enable,
    output wire          rx_enable,
    output wire          force_bad_crc,
    output wire          tdm_highway_on
);
    localparam SW = 5;
    localparam HW = AW + DW + 3;

    // synchronised host and serial pins
    wire [HW-1:0] host_s;
    wire [3:0]    ser_s;
    wire          cs_s;
    wire          rd_s;
    wire          wr_s;
    wire [AW-1:0] addr_s;
    wire [DW-1:0] din_s;
    wire          txc_s;
    wire          rxc_s;
    wire          in_a_s;
    wire          in_b_s;

    pin_sync #(.W(HW)) u_host_sync (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .d       ({cs_b, rd_b, wr_b, addr, data_in}),
        .q       (host_s)
    );

    pin_sync #(.W(4)) u_ser_sync (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .d       ({tx_bit_clock, rx_bit_clock, serial_in_a, serial_in_b}),
        .q       (ser_s)
    );

    assign cs_s   = ~host_s[HW-1];
    assign rd_s   = ~host_s[HW-2];
    assign wr_s   = ~host_s[HW-3];
    assign addr_s = host_s[AW+DW-1:DW];
    assign din_s  = host_s[DW-1:0];
    assign txc_s  = ser_s[3];
    assign rxc_s  = ser_s[2];
    assign in_a_s = ser_s[1];
    assign in_b_s = ser_s[0];

    // register bank, slots 0..15 primary, 16..18 alternate
    reg [DW-1:0] bank_ff [0:`SLOT_COUNT-1];

    function [SW-1:0] slot_of;
        input [AW-1:0] idx;
        input          bank_select;
        begin
            if (bank_select && idx >= `IDX_ALT_FIRST && idx <= `IDX_ALT_LAST)
                slot_of = `SLOT_ALT_BASE + {1'b0, idx - `IDX_ALT_FIRST};
            else
                slot_of = {1'b0, idx};
        end
    endfunction

    function [DW-1:0] default_of;
        input integer slot;
        begin
            if (slot == 0)
                default_of = `RST_CHIP_CONFIG;
            else
                default_of = `RST_DEFAULT;
        end
    endfunction

    function edge_pick;
        input rise;
        input fall;
        input use_fall;
        begin
            edge_pick = use_fall ? fall : rise;
        end
    endfunction

    wire [DW-1:0] chip_cfg  = bank_ff[`IDX_CHIP_CONFIG];
    wire [DW-1:0] op_ctl    = bank_ff[`IDX_OPERATION_CONTROL];
    wire [DW-1:0] rx_ctl    = bank_ff[`IDX_RX_CONTROL];
    wire [DW-1:0] tx_slot   = bank_ff[`IDX_TX_SLOT_SELECT];
    wire [DW-1:0] rx_slot   = bank_ff[`IDX_RX_SLOT_SELECT];
    wire [DW-1:0] edge_cfg  = bank_ff[`IDX_BIT_OFFSET_EDGE];
    wire          alt_sel   = chip_cfg[`BIT_BANK_SELECT];
    wire          local_on  = op_ctl[`BIT_LOCAL_LOOP];
    wire          remote_on = op_ctl[`BIT_REMOTE_LOOP];
    wire          pdown     = op_ctl[`BIT_POWER_DOWN];
    wire          floating  = op_ctl[`BIT_OUTPUT_FLOAT];

    // host strobe tracking
    reg           wr_act_ff;
    reg           rd_act_ff;
    reg [AW-1:0]  wr_addr_ff;
    reg [DW-1:0]  wr_data_ff;
    wire          wr_now   = cs_s & wr_s;
    wire          rd_now   = cs_s & rd_s;
    wire          wr_done  = wr_act_ff & ~wr_now;
    wire          rd_start = rd_now & ~rd_act_ff;
    wire [SW-1:0] wr_slot  = slot_of(wr_addr_ff, alt_sel);
    wire [SW-1:0] rd_slot  = slot_of(addr_s, alt_sel);
    wire          both_rst = wr_done && wr_slot == {1'b0, `IDX_OPERATION_CONTROL}
                             && wr_data_ff[`BIT_TX_SOFT_RESET] && wr_data_ff[`BIT_RX_SOFT_RESET];

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_act_ff  <= 1'b0;
            rd_act_ff  <= 1'b0;
            wr_addr_ff <= {AW{1'b0}};
            wr_data_ff <= {DW{1'b0}};
        end else begin
            wr_act_ff <= wr_now;
            rd_act_ff <= rd_now;
            // capture while strobe is low; commit at its release
            if (wr_now) begin
                wr_addr_ff <= addr_s;
                wr_data_ff <= din_s;
            end
        end
    end

    integer i;
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (i = 0; i < `SLOT_COUNT; i = i + 1)
                bank_ff[i] <= default_of(i);
        end else if (both_rst) begin
            for (i = 0; i < `SLOT_COUNT; i = i + 1)
                bank_ff[i] <= default_of(i);
        end else begin
            if (wr_done) begin
                case (wr_slot)
                    {1'b0, `IDX_TX_STATUS},
                    {1'b0, `IDX_FIFO_DATA_PORT},
                    {1'b0, `IDX_RX_STATUS},
                    {1'b0, `IDX_INTERRUPT_STATUS}: begin
                    end
                    {1'b0, `IDX_OPERATION_CONTROL}: begin
                        // soft reset bits act once and read back as zero
                        bank_ff[wr_slot] <= wr_data_ff & `MASK_SELF_CLEAR;
                    end
                    `SLOT_ALT_BASE: begin
                        // low bits are match status, kept by the core
                        bank_ff[wr_slot] <= wr_data_ff & `MASK_TRANSPARENT_WR;
                    end
                    default: begin
                        bank_ff[wr_slot] <= wr_data_ff;
                    end
                endcase
            end
            // any read start clears the float bit, whatever the index
            if (rd_start)
                bank_ff[`IDX_OPERATION_CONTROL][`BIT_OUTPUT_FLOAT] <= 1'b0;
        end
    end

    // read path
    reg [DW-1:0] rd_value;
    always @* begin
        rd_value = bank_ff[rd_slot];
        case (rd_slot)
            {1'b0, `IDX_TX_STATUS}:        rd_value = tx_status_in;
            {1'b0, `IDX_FIFO_DATA_PORT}:   rd_value = fifo_rd_data;
            {1'b0, `IDX_RX_STATUS}:        rd_value = rx_status_in;
            {1'b0, `IDX_INTERRUPT_STATUS}: rd_value = int_status_in;
            `SLOT_ALT_BASE:                rd_value = {bank_ff[rd_slot][DW-1:5], transparent_status_in};
            default:                       rd_value = bank_ff[rd_slot];
        endcase
    end

    reg [DW-1:0] data_out_ff;
    reg          data_oe_b_ff;
    reg          fifo_wr_strobe_ff;
    reg [DW-1:0] fifo_wr_data_ff;
    reg          fifo_rd_strobe_ff;
    reg          tx_fifo_clear_ff;
    reg          rx_fifo_clear_ff;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_out_ff       <= {DW{1'b0}};
            data_oe_b_ff      <= 1'b1;
            fifo_wr_strobe_ff <= 1'b0;
            fifo_wr_data_ff   <= {DW{1'b0}};
            fifo_rd_strobe_ff <= 1'b0;
            tx_fifo_clear_ff  <= 1'b0;
            rx_fifo_clear_ff  <= 1'b0;
        end else begin
            data_out_ff       <= rd_now ? rd_value : {DW{1'b0}};
            // the clearing read itself still drives the bus
            data_oe_b_ff      <= ~rd_now | (floating & ~rd_start);
            fifo_wr_strobe_ff <= wr_done && wr_slot == {1'b0, `IDX_FIFO_DATA_PORT};
            fifo_wr_data_ff   <= wr_data_ff;
            fifo_rd_strobe_ff <= rd_start && rd_slot == {1'b0, `IDX_FIFO_DATA_PORT};
            tx_fifo_clear_ff  <= wr_done && wr_slot == {1'b0, `IDX_OPERATION_CONTROL}
                                 && wr_data_ff[`BIT_TX_SOFT_RESET];
            rx_fifo_clear_ff  <= wr_done && wr_slot == {1'b0, `IDX_OPERATION_CONTROL}
                                 && wr_data_ff[`BIT_RX_SOFT_RESET];
        end
    end

    // bit clock edges, gated by power down
    reg  txc_d_ff;
    reg  rxc_d_ff;
    wire txc_rise = txc_s & ~txc_d_ff;
    wire txc_fall = ~txc_s & txc_d_ff;
    wire rxc_rise = rxc_s & ~rxc_d_ff;
    wire rxc_fall = ~rxc_s & rxc_d_ff;
    wire rx_from_tx = local_on | (remote_on & rx_ctl[`BIT_RX_CLK_FROM_TX]);

    // receive samples on the edge opposite to the one that launches
    wire tx_edge = ~pdown & edge_pick(txc_rise, txc_fall, edge_cfg[`BIT_TX_CLOCK_INVERT]);
    wire rx_edge = ~pdown & (rx_from_tx ?
                   edge_pick(txc_fall, txc_rise, edge_cfg[`BIT_RX_CLOCK_INVERT]) :
                   edge_pick(rxc_fall, rxc_rise, edge_cfg[`BIT_RX_CLOCK_INVERT]));

    wire pin_bit  = rx_slot[`BIT_INPUT_CHOICE] ? in_b_s : in_a_s;
    // pins ignored in local loop; local wins if both loops are set
    wire rx_src   = local_on ? tx_serial_bit : pin_bit;
    wire loop_bit;

    loop_retimer #(.DW(DW)) u_retimer (
        .sys_clk        (sys_clk),
        .rst_b          (rst_b),
        .rx_strobe      (rx_edge & remote_on),
        .tx_strobe      (tx_edge & remote_on),
        .rx_bit         (pin_bit),
        .highway_on     (chip_cfg[`BIT_HIGHWAY_ON]),
        .rx_slot_active (rx_slot_active),
        .tx_slot_active (tx_slot_active),
        .loop_bit       (loop_bit)
    );

    reg txc_out_ff;
    reg rx_bit_ff;
    reg rx_strobe_ff;
    reg tx_strobe_ff;
    reg out_a_ff;
    reg out_b_ff;
    reg out_a_oe_b_ff;
    reg out_b_oe_b_ff;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            txc_d_ff      <= 1'b1;
            rxc_d_ff      <= 1'b1;
            txc_out_ff    <= 1'b1;
            rx_bit_ff     <= 1'b1;
            rx_strobe_ff  <= 1'b0;
            tx_strobe_ff  <= 1'b0;
            out_a_ff      <= 1'b1;
            out_b_ff      <= 1'b1;
            out_a_oe_b_ff <= 1'b1;
            out_b_oe_b_ff <= 1'b1;
        end else begin
            txc_d_ff     <= txc_s;
            rxc_d_ff     <= rxc_s;
            tx_strobe_ff <= tx_edge;
            // remote loop still delivers received bits to the receiver
            rx_strobe_ff <= rx_edge;
            if (rx_edge)
                rx_bit_ff <= rx_src;
            if (tx_edge) begin
                // remote loop replaces transmitter data on the pins
                txc_out_ff <= remote_on & ~local_on ? loop_bit : tx_serial_bit;
            end
            out_a_ff      <= txc_out_ff;
            out_b_ff      <= txc_out_ff;
            out_a_oe_b_ff <= ~tx_slot[`BIT_OUT_A_ENABLE] | floating;
            out_b_oe_b_ff <= ~tx_slot[`BIT_OUT_B_ENABLE] | floating;
        end
    end

    assign data_out          = data_out_ff;
    assign data_oe_b         = data_oe_b_ff;
    assign serial_out_a      = out_a_ff;
    assign serial_out_b      = out_b_ff;
    assign serial_out_a_oe_b = out_a_oe_b_ff;
    assign serial_out_b_oe_b = out_b_oe_b_ff;
    assign rx_serial_bit     = rx_bit_ff;
    assign rx_bit_strobe     = rx_strobe_ff;
    assign tx_bit_strobe     = tx_strobe_ff;
    assign fifo_wr_strobe    = fifo_wr_strobe_ff;
    assign fifo_wr_data      = fifo_wr_data_ff;
    assign fifo_rd_strobe    = fifo_rd_strobe_ff;
    assign tx_fifo_clear     = tx_fifo_clear_ff;
    assign rx_fifo_clear     = rx_fifo_clear_ff;
    assign tx_enable         = op_ctl[`BIT_TX_ENABLE];
    assign rx_enable         = op_ctl[`BIT_RX_ENABLE];
    assign force_bad_crc     = bank_ff[`IDX_INTERRUPT_MASK][`BIT_FORCE_BAD_CRC];
    assign tdm_highway_on    = chip_cfg[`BIT_HIGHWAY_ON];
endmodule
`default_nettype wire

/* hw/hdlc_diag_defs.vh */
// Summary of operation
// - op control bit 1 enters local loopback
// - op control bit 0 enters remote loopback
// - loops work any highway mode; else independent
// - rx slot bit 7 picks input A/B
// - tx slot bits 7/6 enable outputs A/B
// - local loop clocks both sides from tx clock
// - local loop feeds tx output to receiver
// - local loop ignores inputs, outputs stay selected
// - remote loop no highway: retime within two bits
// - remote loop highway: resend in next tx slot
// - remote loop: tx off, rx still stores
// - reset pin floats outputs, clears everything, clockless
// - float bit tri-states outputs, first read clears
// - both soft reset bits reset registers, no float
// - force bad crc bit corrupts every frame crc
// - power down blocks both bit clocks internally
// - bank select maps indices 11-13 to alternates
//
// Purpose: register indices, field positions and reset values
// Assumes: 8-bit registers, 4-bit host index
// Notes:   slots 16..18 hold the alternate bank
`ifndef HDLC_DIAG_DEFS_VH
`define HDLC_DIAG_DEFS_VH

`define IDX_CHIP_CONFIG        4'h0
`define IDX_TX_CONTROL         4'h1
`define IDX_TX_STATUS          4'h2
`define IDX_FIFO_DATA_PORT     4'h3
`define IDX_RX_STATUS          4'h4
`define IDX_RX_CONTROL         4'h5
`define IDX_OPERATION_CONTROL  4'h6
`define IDX_TX_SLOT_SELECT     4'h7
`define IDX_RX_SLOT_SELECT     4'h8
`define IDX_BIT_OFFSET_EDGE    4'h9
`define IDX_TX_SLOT_OFFSET     4'hA
`define IDX_RX_SLOT_OFFSET     4'hB
`define IDX_RX_BIT_MASK        4'hC
`define IDX_TX_BIT_MASK        4'hD
`define IDX_INTERRUPT_MASK     4'hE
`define IDX_INTERRUPT_STATUS   4'hF
`define IDX_ALT_FIRST          4'hB
`define IDX_ALT_LAST           4'hD
`define SLOT_ALT_BASE          5'h10
`define SLOT_COUNT             19

`define BIT_HIGHWAY_ON         7
`define BIT_BANK_SELECT        4
`define BIT_RX_CLK_FROM_TX     6
`define BIT_POWER_DOWN         7
`define BIT_OUTPUT_FLOAT       6
`define BIT_TX_SOFT_RESET      5
`define BIT_RX_SOFT_RESET      4
`define BIT_TX_ENABLE          3
`define BIT_RX_ENABLE          2
`define BIT_LOCAL_LOOP         1
`define BIT_REMOTE_LOOP        0
`define BIT_OUT_A_ENABLE       7
`define BIT_OUT_B_ENABLE       6
`define BIT_INPUT_CHOICE       7
`define BIT_TX_CLOCK_INVERT    4
`define BIT_RX_CLOCK_INVERT    0
`define BIT_FORCE_BAD_CRC      7
`define BIT_FACTORY_TEST       7

`define RST_CHIP_CONFIG        8'h40
`define RST_DEFAULT            8'h00
`define MASK_SELF_CLEAR        8'hCF
`define MASK_TRANSPARENT_WR    8'hE0

`endif

/* hw/pin_sync.v */
// Purpose: two-flop synchroniser for pins from outside sys_clk
// Assumes: each bit is an independent level
// Notes:   only the second stage may be read
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter W = 1
) (
    input  wire         sys_clk,
    input  wire         rst_b,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= {W{1'b1}};
            sync_ff <= {W{1'b1}};
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule
`default_nettype wire

/* hw/loop_retimer.v */
// Purpose: remote loop path from received bit to transmitted bit
// Assumes: strobes already gated by power down
// Notes:   highway mode buffers one octet between slots
`timescale 1ns/1ps
`default_nettype none
module loop_retimer #(
    parameter DW = 8
) (
    input  wire sys_clk,
    input  wire rst_b,
    input  wire rx_strobe,
    input  wire tx_strobe,
    input  wire rx_bit,
    input  wire highway_on,
    input  wire rx_slot_active,
    input  wire tx_slot_active,
    output wire loop_bit
);
    reg          hold_ff;
    reg          out_ff;
    reg [DW-1:0] rx_sr_ff;
    reg [DW-1:0] tx_sr_ff;
    reg          rx_slot_d_ff;
    wire         rx_slot_end;

    assign rx_slot_end = rx_slot_d_ff & ~rx_slot_active;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_ff      <= 1'b1;
            out_ff       <= 1'b1;
            rx_sr_ff     <= {DW{1'b1}};
            tx_sr_ff     <= {DW{1'b1}};
            rx_slot_d_ff <= 1'b0;
        end else begin
            rx_slot_d_ff <= rx_slot_active;
            if (!highway_on) begin
                // one bit held on rx edge, sent on next tx edge: under two bits late
                if (rx_strobe)
                    hold_ff <= rx_bit;
                if (tx_strobe)
                    out_ff <= hold_ff;
            end else begin
                if (rx_strobe && rx_slot_active)
                    rx_sr_ff <= {rx_bit, rx_sr_ff[DW-1:1]};
                if (rx_slot_end)
                    tx_sr_ff <= rx_sr_ff;
                else if (tx_strobe && tx_slot_active) begin
                    out_ff   <= tx_sr_ff[0];
                    tx_sr_ff <= {1'b1, tx_sr_ff[DW-1:1]};
                end
            end
        end
    end

    assign loop_bit = out_ff;
endmodule
`default_nettype wire

/* verif/hdlc_diag_loopback_ctrl_props.sv */
// Purpose: concurrent checks on the diagnostic block's ports
// Assumes: host pins are held low for at least 4 cycles per access
// Notes:   pin-to-output delays allow for the two synchroniser flops
`timescale 1ns/1ps
`default_nettype none
module hdlc_diag_props #(
    parameter DW = 8,
    parameter AW = 4
) (
    input wire logic          sys_clk,
    input wire logic          rst_b,
    input wire logic          cs_b,
    input wire logic          rd_b,
    input wire logic          wr_b,
    input wire logic [DW-1:0] data_out,
    input wire logic          data_oe_b,
    input wire logic          tx_bit_clock,
    input wire logic          serial_out_a_oe_b,
    input wire logic          serial_out_b_oe_b,
    input wire logic          rx_bit_strobe,
    input wire logic          tx_bit_strobe,
    input wire logic          tx_fifo_clear,
    input wire logic          rx_fifo_clear,
    input wire logic          tx_enable,
    input wire logic          force_bad_crc
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    reset_float_a: assert property ($rose(rst_b) |-> data_oe_b && serial_out_a_oe_b && serial_out_b_oe_b)
        else $error("output driven straight out of reset");
    read_drive_a: assert property ($fell(data_oe_b) |-> !$past(cs_b, 2) && !$past(rd_b, 2))
        else $error("data bus driven without a host read");
    idle_zero_a: assert property (data_oe_b |-> data_out == {DW{1'b0}})
        else $error("read data not zero while bus floats");
    tx_pulse_a: assert property (tx_bit_strobe |=> !tx_bit_strobe)
        else $error("tx strobe longer than one cycle");
    tx_edge_a: assert property (tx_bit_strobe |-> $past(tx_bit_clock, 2) != $past(tx_bit_clock, 6))
        else $error("tx strobe without a tx clock edge");
    rx_pulse_a: assert property (rx_bit_strobe |=> !rx_bit_strobe [*3])
        else $error("rx strobes too close together");
    clear_cause_a: assert property (tx_fifo_clear || rx_fifo_clear |-> !$past(cs_b, 6) && !$past(wr_b, 6))
        else $error("fifo clear without a host write");
    level_cause_a: assert property (!$stable(tx_enable) || !$stable(force_bad_crc) |-> !$past(cs_b, 6))
        else $error("control level moved without a host write");
    float_cause_a: assert property (!$stable(serial_out_a_oe_b) |-> !$past(cs_b, 3) || !$past(cs_b, 6))
        else $error("serial enable moved without host access");
endmodule
bind hdlc_diag_loopback_ctrl hdlc_diag_props #(.DW(DW), .AW(AW)) props (
    .sys_clk(sys_clk), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .data_out(data_out),
    .data_oe_b(data_oe_b), .tx_bit_clock(tx_bit_clock), .serial_out_a_oe_b(serial_out_a_oe_b),
    .serial_out_b_oe_b(serial_out_b_oe_b), .rx_bit_strobe(rx_bit_strobe), .tx_bit_strobe(tx_bit_strobe),
    .tx_fifo_clear(tx_fifo_clear), .rx_fifo_clear(rx_fifo_clear), .tx_enable(tx_enable),
    .force_bad_crc(force_bad_crc));
`default_nettype wire

/* verif/line_partner.sv */
// Purpose: line transceiver model driving bit clocks and serial inputs
// Assumes: data changes on the tx clock rise, stable at the fall
// Notes:   clock stands high while run is low; phase offset from sys_clk
`timescale 1ns/1ps
`default_nettype none
module line_partner (
    input  wire logic run,
    input  wire logic a_val,
    input  wire logic b_val,
    output var logic  tx_bit_clock,
    output var logic  rx_bit_clock,
    output var logic  serial_in_a,
    output var logic  serial_in_b
);
    initial begin
        tx_bit_clock = 1'b1;
        rx_bit_clock = 1'b1; // rx clock held still, receiver runs from tx clock
        serial_in_a = 1'b1;
        serial_in_b = 1'b1;
        #37;
        forever begin
            #100;
            if (run) begin
                tx_bit_clock = ~tx_bit_clock;
                if (tx_bit_clock) begin
                    serial_in_a = a_val;
                    serial_in_b = b_val;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* verif/hdlc_diag_loopback_ctrl_tb.sv */
// Purpose: self-checking bench for the diagnostic and loopback block
// Assumes: host write strobes held 5 cycles, read strobes 4; line model bit clock of 200 ns
// Notes:   rx bit clock stays still, so rx strobes prove tx clock routing
`timescale 1ns/1ps
`default_nettype none
module hdlc_diag_loopback_ctrl_tb;
    logic       sys_clk, run = 0, a_val = 1, b_val = 1, tx_serial_bit = 1;
    logic       rst_b = 0, cs_b = 1, rd_b = 1, wr_b = 1;
    logic [3:0] addr = 4'h0;
    logic [7:0] data_in = 8'h00, st = 8'h5A, v;
    logic [1:0] got, clrs = 2'b00;
    logic [3:0] rw_idx [10] = '{4'h1, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
    wire  [7:0] data_out;
    wire        data_oe_b, tx_clk, rx_clk, in_a, in_b, out_a, out_b, oe_a, oe_b;
    wire        rx_bit, rx_stb, tx_stb, tx_clr, rx_clr, tx_en, bad_crc, rx_en, hwy;
    int         errors = 0, n_tests = 0, cyc = 0, rxs = 0, lmis = 0;

    hdlc_diag_loopback_ctrl uut (
        .sys_clk(sys_clk), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe_b(data_oe_b), .tx_bit_clock(tx_clk),
        .rx_bit_clock(rx_clk), .serial_in_a(in_a), .serial_in_b(in_b), .serial_out_a(out_a),
        .serial_out_a_oe_b(oe_a), .serial_out_b(out_b), .serial_out_b_oe_b(oe_b),
        .tx_serial_bit(tx_serial_bit), .rx_slot_active(1'b0), .tx_slot_active(1'b0),
        .rx_serial_bit(rx_bit), .rx_bit_strobe(rx_stb), .tx_bit_strobe(tx_stb), .tx_status_in(st),
        .rx_status_in(~st), .int_status_in(st ^ 8'h0F), .fifo_rd_data(st ^ 8'hF0),
        .transparent_status_in(st[4:0]), .fifo_wr_strobe(), .fifo_wr_data(), .fifo_rd_strobe(),
        .tx_fifo_clear(tx_clr), .rx_fifo_clear(rx_clr), .tx_enable(tx_en), .rx_enable(rx_en),
        .force_bad_crc(bad_crc), .tdm_highway_on(hwy));
    line_partner far (.run(run), .a_val(a_val), .b_val(b_val), .tx_bit_clock(tx_clk),
        .rx_bit_clock(rx_clk), .serial_in_a(in_a), .serial_in_b(in_b));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        clrs <= clrs | {tx_clr === 1'b1, rx_clr === 1'b1};
        if (rx_stb === 1'b1) begin
            rxs <= rxs + 1;
            if (rx_bit !== tx_serial_bit) lmis <= lmis + 1;
        end
        if (cyc == 6000) begin
            errors++;
            results();
        end
    end

    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        tick(1);
        cs_b = 1'b0;
        wr_b = 1'b0;
        addr = a;
        data_in = d;
        tick(5);
        cs_b = 1'b1;
        wr_b = 1'b1;
        tick(5);
    endtask
    task rdc(input logic [3:0] a, input logic [7:0] exp_v);
        int k;
        k = 0;
        tick(1);
        cs_b = 1'b0;
        rd_b = 1'b0;
        addr = a;
        while (data_oe_b !== 1'b0 && k < 20) begin
            tick(1);
            k++;
        end
        tick(1);
        chk(data_out, exp_v);
        cs_b = 1'b1;
        rd_b = 1'b1;
        tick(4);
    endtask
    task chk(input logic [7:0] got_v, input logic [7:0] exp_v);
        n_tests++;
        if (got_v !== exp_v) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask
    task done(input string s);
        $display("test %s finished, mismatches so far %0d", s, errors);
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        tick(4);
        rst_b = 1'b1;
        chk({5'h00, data_oe_b, oe_a, oe_b}, 8'h07);
        rdc(4'h0, 8'h40);
        rdc(4'h6, 8'h00);
        done("reset");
        foreach (rw_idx[i]) wr(rw_idx[i], 8'h5A ^ {rw_idx[i], rw_idx[i]});
        foreach (rw_idx[i]) rdc(rw_idx[i], 8'h5A ^ {rw_idx[i], rw_idx[i]});
        chk({7'h00, bad_crc}, 8'h01);
        wr(4'hE, 8'h00);
        chk({7'h00, bad_crc}, 8'h00);
        for (int j = 0; j < 2; j++) begin
            st = j ? 8'hA5 : 8'h5A;
            wr(4'h2, 8'hFF);
            wr(4'h4, 8'hFF);
            wr(4'hF, 8'hFF);
            rdc(4'h2, st);
            rdc(4'h4, ~st);
            rdc(4'hF, st ^ 8'h0F);
            rdc(4'h3, st ^ 8'hF0);
        end
        done("register map");
        wr(4'h0, 8'h50);
        wr(4'hC, 8'h3C);
        rdc(4'hC, 8'h3C);
        wr(4'hB, 8'h7F);
        rdc(4'hB, {3'b011, st[4:0]});
        wr(4'h0, 8'h40);
        rdc(4'hC, 8'h96);
        rdc(4'hB, 8'hE1);
        done("bank select");
        for (int j = 0; j < 4; j++) begin
            v = {j[1:0], 6'h00};
            wr(4'h7, v);
            chk({6'h00, oe_a, oe_b}, {6'h00, ~v[7:6]});
        end
        wr(4'h6, 8'h40);
        chk({6'h00, oe_a, oe_b}, 8'h03);
        wr(4'hD, 8'h77);
        rdc(4'hD, 8'h77);
        chk({6'h00, oe_a, oe_b}, 8'h00);
        rdc(4'h6, 8'h00);
        done("outputs and float");
        clrs = 2'b00;
        wr(4'h6, 8'h30);
        chk({6'h00, clrs}, 8'h03);
        rdc(4'h7, 8'h00);
        rdc(4'h0, 8'h40);
        rdc(4'hD, 8'h00);
        done("soft reset");
        wr(4'h7, 8'hC0);
        run = 1'b1;
        for (int h = 0; h < 2; h++) begin
            wr(4'h0, {h[0], 7'h40});
            wr(4'h6, 8'h0E);
            for (int b = 0; b < 2; b++) begin
                tx_serial_bit = b[0];
                a_val = ~b[0];
                b_val = ~b[0];
                tick(24);
                rxs = 0;
                lmis = 0;
                tick(48);
                chk({7'h00, rxs > 0}, 8'h01);
                chk(lmis[7:0], 8'h00);
                chk({4'h0, rx_en, hwy, oe_a, oe_b}, {5'h01, h[0], 2'b00});
            end
            wr(4'h6, 8'h0C);
            tick(8);
            rxs = 0;
            tick(48);
            chk(rxs[7:0], 8'h00);
        end
        done("local loop");
        wr(4'h0, 8'h40);
        wr(4'h5, 8'h40);
        wr(4'hC, 8'hFF);
        wr(4'hD, 8'hFF);
        wr(4'h7, 8'h80);
        wr(4'h6, 8'h01);
        a_val = 1'b1;
        b_val = 1'b0;
        for (int s = 0; s < 2; s++) begin
            wr(4'h8, {s[0], 7'h00});
            tick(40);
            got[s] = out_a;
        end
        chk({7'h00, got[0] ^ got[1]}, 8'h01);
        for (int b = 0; b < 2; b++) begin
            a_val = b[0];
            b_val = b[0];
            tick(32);
            chk({6'h00, out_a, out_b}, {6'h00, b[0], b[0]});
        end
        wr(4'h6, 8'h81);
        a_val = 1'b0;
        b_val = 1'b0;
        tick(40);
        chk({6'h00, out_a, out_b}, 8'h03);
        wr(4'h6, 8'h01);
        tick(32);
        chk({6'h00, out_a, out_b}, 8'h00);
        done("remote loop and power down");
        results();
    end
endmodule
`default_nettype wire
